// File: rtl/srec_pkg.sv
// Shared constants, types and helpers for the S-record loader.
package srec_pkg;

  localparam logic [7:0] CH_S       = 8'h53;
  localparam logic [7:0] CH_ONE     = 8'h31;
  localparam logic [7:0] CH_NINE    = 8'h39;
  localparam logic [7:0] CH_DIG0    = 8'h30;
  localparam logic [7:0] CH_DIG9    = 8'h39;
  localparam logic [7:0] CH_UPA     = 8'h41;
  localparam logic [7:0] CH_UPF     = 8'h46;
  localparam logic [7:0] CH_LOA     = 8'h61;
  localparam logic [7:0] CH_LOF     = 8'h66;
  localparam logic [7:0] CH_TEN     = 8'h0A;

  // Smallest legal count: two address bytes plus the checksum byte.
  localparam logic [7:0] MIN_LEN    = 8'h03;
  // A termination record carries exactly the address and checksum.
  localparam logic [7:0] TERM_LEN   = 8'h03;
  localparam logic [7:0] LAST_ONE   = 8'h01;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam logic [15:0] ADDR_RST  = 16'h0000;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [3:0] NIB_RST    = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TYPE = 3'b010,
    ST_BODY = 3'b100
  } state_e;

  typedef enum logic [3:0] {
    PH_LEN  = 4'b0001,
    PH_AHI  = 4'b0010,
    PH_ALO  = 4'b0100,
    PH_DATA = 4'b1000
  } phase_e;

  typedef struct packed {
    logic       vld;
    logic [7:0] code;
  } char_s;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } mem_wr_s;

  // Maps an ASCII hex digit to {valid, nibble}; anything else is invalid.
  function automatic logic [4:0] hex_nib(input logic [7:0] c);
    logic [7:0] t;
    t = 8'h00;
    if (c >= CH_DIG0 && c <= CH_DIG9) begin
      t = c - CH_DIG0;
      return {1'b1, t[3:0]};
    end else if (c >= CH_UPA && c <= CH_UPF) begin
      t = c - CH_UPA + CH_TEN;
      return {1'b1, t[3:0]};
    end else if (c >= CH_LOA && c <= CH_LOF) begin
      t = c - CH_LOA + CH_TEN;
      return {1'b1, t[3:0]};
    end
    return {1'b0, NIB_RST};
  endfunction : hex_nib

endpackage : srec_pkg

// File: rtl/hex_pair_join.sv
// Joins two ASCII hex characters into one byte, first character high.
`timescale 1ns/10ps
module hex_pair_join (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          clr,
  input  wire srec_pkg::char_s ch,
  output logic               byte_vld,
  output logic [7:0]         byte_val,
  output logic               bad_hex
);

  logic [4:0] dec;
  logic [3:0] hi_r;
  logic       have_hi_r;

  assign dec      = srec_pkg::hex_nib(ch.code);
  assign bad_hex  = ch.vld & ~dec[4];
  assign byte_vld = ch.vld & dec[4] & have_hi_r;
  assign byte_val = {hi_r, dec[3:0]};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_r      <= srec_pkg::NIB_RST;
      have_hi_r <= 1'b0;
    end else if (clr || bad_hex) begin
      have_hi_r <= 1'b0;
    end else if (ch.vld) begin
      hi_r      <= dec[3:0];
      have_hi_r <= ~have_hi_r;
    end
  end

  chk_pair_nibble: assert property (@(posedge clk) disable iff (!rst_b)
    byte_vld |-> have_hi_r && byte_val[7:4] == hi_r && byte_val[3:0] == dec[3:0])
    else $error("Pair byte low nibble does not match the second character.");

endmodule : hex_pair_join

// File: rtl/srec_loader.sv
// S-record text decoder that turns code/data records into byte memory writes.
`timescale 1ns/10ps
module srec_loader (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire srec_pkg::char_s ch,
  output srec_pkg::mem_wr_s    mem_wr,
  output logic                 rec_ok,
  output logic                 rec_err,
  output logic                 load_done,
  output logic [15:0]          start_addr,
  output logic                 loading
);

  srec_pkg::state_e  state_r;
  srec_pkg::phase_e  phase_r;
  logic              first_seen_r;
  logic              is_term_r;
  logic [7:0]        rem_r;
  logic [7:0]        sum_r;
  logic [15:0]       addr_r;
  srec_pkg::mem_wr_s wr_r;
  logic              rec_ok_r;
  logic              rec_err_r;
  logic              done_r;
  logic [15:0]       start_addr_r;

  logic       pair_vld;
  logic [7:0] pair_byte;
  logic       pair_bad;
  logic       in_body;
  logic       byte_ev;
  logic       len_bad;
  logic       ck_ev;
  logic       ck_good;
  logic       type_ev;
  logic       type_bad;
  logic       err_ev;
  logic       ok_ev;
  logic       wr_ev;
  logic [7:0] sum_nxt;
  logic [4:0] ch_nib;

  srec_pkg::char_s body_ch;

  assign in_body = (state_r == srec_pkg::ST_BODY);
  assign body_ch = {ch.vld & in_body, ch.code};
  assign ch_nib  = srec_pkg::hex_nib(ch.code);

  hex_pair_join u_pair (
    .clk      (clk),
    .rst_b    (rst_b),
    .clr      (~in_body),
    .ch       (body_ch),
    .byte_vld (pair_vld),
    .byte_val (pair_byte),
    .bad_hex  (pair_bad)
  );

  assign byte_ev  = pair_vld;
  assign sum_nxt  = sum_r + pair_byte;
  assign len_bad  = (pair_byte < srec_pkg::MIN_LEN) || (is_term_r && pair_byte != srec_pkg::TERM_LEN);
  assign ck_ev    = byte_ev && phase_r == srec_pkg::PH_DATA && rem_r == srec_pkg::LAST_ONE;
  assign ck_good  = (pair_byte == ~sum_r);
  assign type_ev  = (state_r == srec_pkg::ST_TYPE) && ch.vld;
  assign type_bad = type_ev && first_seen_r && ch.code != srec_pkg::CH_ONE && ch.code != srec_pkg::CH_NINE;
  // A separator or any other non-hex character inside the body means the
  // record ended early; it is flagged through pair_bad alone, not by the length check.
  assign err_ev   = pair_bad || (byte_ev && phase_r == srec_pkg::PH_LEN && len_bad) ||
                    (ck_ev && !ck_good) || type_bad;
  assign ok_ev    = ck_ev && ck_good;
  assign wr_ev    = byte_ev && phase_r == srec_pkg::PH_DATA && rem_r != srec_pkg::LAST_ONE && !is_term_r;

  // Record framing.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= srec_pkg::ST_IDLE;
    end else begin
      case (state_r)
        srec_pkg::ST_IDLE: begin
          // Line numbers, separators and header text never match the start letter.
          if (ch.vld && ch.code == srec_pkg::CH_S) begin
            state_r <= srec_pkg::ST_TYPE;
          end
        end
        srec_pkg::ST_TYPE: begin
          if (ch.vld) begin
            if (ch.code == srec_pkg::CH_ONE || (first_seen_r && ch.code == srec_pkg::CH_NINE)) begin
              state_r <= srec_pkg::ST_BODY;
            end else begin
              state_r <= srec_pkg::ST_IDLE;
            end
          end
        end
        srec_pkg::ST_BODY: begin
          if (err_ev || ok_ev) begin
            state_r <= srec_pkg::ST_IDLE;
          end
        end
        default: state_r <= srec_pkg::ST_IDLE;
      endcase
    end
  end

  // Block tracking: nothing loads until the first code/data record.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_seen_r <= 1'b0;
      is_term_r    <= 1'b0;
    end else if (type_ev && ch.code == srec_pkg::CH_ONE) begin
      first_seen_r <= 1'b1;
      is_term_r    <= 1'b0;
    end else if (type_ev && first_seen_r && ch.code == srec_pkg::CH_NINE) begin
      is_term_r    <= 1'b1;
    end else if (ok_ev && is_term_r) begin
      first_seen_r <= 1'b0;
    end
  end

  // Field walk, byte count, running sum and load address.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= srec_pkg::PH_LEN;
      rem_r   <= srec_pkg::BYTE_RST;
      sum_r   <= srec_pkg::BYTE_RST;
      addr_r  <= srec_pkg::ADDR_RST;
    end else if (!in_body) begin
      phase_r <= srec_pkg::PH_LEN;
    end else if (byte_ev) begin
      case (phase_r)
        srec_pkg::PH_LEN: begin
          rem_r   <= pair_byte;
          sum_r   <= pair_byte;
          phase_r <= srec_pkg::PH_AHI;
        end
        srec_pkg::PH_AHI: begin
          addr_r[15:8] <= pair_byte;
          rem_r        <= rem_r - srec_pkg::LAST_ONE;
          sum_r        <= sum_nxt;
          phase_r      <= srec_pkg::PH_ALO;
        end
        srec_pkg::PH_ALO: begin
          addr_r[7:0] <= pair_byte;
          rem_r       <= rem_r - srec_pkg::LAST_ONE;
          sum_r       <= sum_nxt;
          phase_r     <= srec_pkg::PH_DATA;
        end
        srec_pkg::PH_DATA: begin
          if (wr_ev) begin
            addr_r <= addr_r + srec_pkg::ADDR_STEP;
            rem_r  <= rem_r - srec_pkg::LAST_ONE;
            sum_r  <= sum_nxt;
          end
        end
        default: phase_r <= srec_pkg::PH_LEN;
      endcase
    end
  end

  // Memory write port.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r <= '0;
    end else begin
      wr_r.en <= wr_ev;
      if (wr_ev) begin
        wr_r.addr <= addr_r;
        wr_r.data <= pair_byte;
      end
    end
  end

  // Record status pulses.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rec_ok_r  <= 1'b0;
      rec_err_r <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      rec_ok_r  <= ok_ev;
      rec_err_r <= err_ev;
      done_r    <= ok_ev && is_term_r;
    end
  end

  // Execution start address taken from a good termination record.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_addr_r <= srec_pkg::ADDR_RST;
    end else if (ok_ev && is_term_r) begin
      start_addr_r <= addr_r;
    end
  end

  assign mem_wr     = wr_r;
  assign rec_ok     = rec_ok_r;
  assign rec_err    = rec_err_r;
  assign load_done  = done_r;
  assign start_addr = start_addr_r;
  assign loading    = first_seen_r;

  chk_write_in_body: assert property (@(posedge clk) disable iff (!rst_b)
    wr_r.en |-> $past(in_body && !is_term_r && first_seen_r))
    else $error("Memory write outside a code/data record body.");

  chk_write_addr: assert property (@(posedge clk) disable iff (!rst_b)
    wr_r.en |-> addr_r == wr_r.addr + srec_pkg::ADDR_STEP)
    else $error("Load address did not step after a write.");

  chk_sum_good: assert property (@(posedge clk) disable iff (!rst_b)
    ck_ev |=> (rec_ok_r == (&$past(sum_nxt))) && (rec_err_r == !(&$past(sum_nxt))))
    else $error("Checksum verdict does not match complemented sum.");

  chk_err_stops: assert property (@(posedge clk) disable iff (!rst_b)
    rec_err_r |-> !wr_r.en ##1 !wr_r.en [*5])
    else $error("Write issued right after a record error.");

  chk_hunt_discard: assert property (@(posedge clk) disable iff (!rst_b)
    !first_seen_r |=> !wr_r.en)
    else $error("Write before the first code/data record.");

  chk_type_reject: assert property (@(posedge clk) disable iff (!rst_b)
    type_bad |=> rec_err_r && state_r == srec_pkg::ST_IDLE)
    else $error("Unsupported record type was not rejected.");

  chk_nonhex_err: assert property (@(posedge clk) disable iff (!rst_b)
    (in_body && ch.vld && !ch_nib[4]) |=> rec_err_r && state_r == srec_pkg::ST_IDLE)
    else $error("Non-hex character inside a record was not flagged.");

  chk_len_short: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_ev && phase_r == srec_pkg::PH_LEN && pair_byte < srec_pkg::MIN_LEN) |=> rec_err_r)
    else $error("Too short length field was accepted.");

  chk_done_addr: assert property (@(posedge clk) disable iff (!rst_b)
    done_r |-> rec_ok_r && start_addr_r == $past(addr_r) && !first_seen_r)
    else $error("Start address not captured at termination.");

  chk_idle_skip: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == srec_pkg::ST_IDLE && ch.vld && ch.code != srec_pkg::CH_S) |=> state_r == srec_pkg::ST_IDLE)
    else $error("Separator or leading character left the idle state.");

  cov_write: cover property (@(posedge clk) disable iff (!rst_b) wr_r.en ##1 wr_r.en);
  cov_rec_ok: cover property (@(posedge clk) disable iff (!rst_b) rec_ok_r && !is_term_r);
  cov_done: cover property (@(posedge clk) disable iff (!rst_b) done_r);
  cov_err: cover property (@(posedge clk) disable iff (!rst_b) rec_err_r);

endmodule : srec_loader

// File: verification/srec_host.sv
// Host model that sends S-record text to the loader one character per strobe.
`timescale 1ns/10ps
module srec_host (
  input  wire logic        clk,
  output srec_pkg::char_s  ch
);
  initial ch = '0;

  // Each character travels as its ASCII code; a released code line shows the inverse of the last one.
  task put(input logic [7:0] c, input int gap);
    ch = '{vld: 1'b1, code: c};
    @(posedge clk);
    #1;
    if (gap > 0) begin
      ch = '{vld: 1'b0, code: ~c};
      repeat (gap) begin
        @(posedge clk);
        #1;
      end
    end
  endtask : put

  task send(input string s, input int gap);
    for (int i = 0; i < s.len(); i++) begin
      put(s[i], gap);
    end
    ch = '{vld: 1'b0, code: ~ch.code};
    @(posedge clk);
    #1;
  endtask : send
endmodule : srec_host

// File: verification/srec_loader_tb.sv
// Self-checking testbench for the S-record loader.
`timescale 1ns/10ps
module srec_loader_tb;
  logic               clk;
  logic               rst_b;
  srec_pkg::char_s    ch;
  srec_pkg::mem_wr_s  mem_wr;
  logic               rec_ok;
  logic               rec_err;
  logic               load_done;
  logic               loading;
  logic [15:0]        start_addr;
  int                 n_mismatch = 0;
  int                 samples_checked = 0;
  int                 n_ok = 0;
  int                 n_err = 0;
  int                 n_done = 0;
  int                 cyc = 0;
  logic [15:0]        wa[$];
  logic [7:0]         wd[$];

  srec_loader srec_loader_inst (.clk(clk), .rst_b(rst_b), .ch(ch), .mem_wr(mem_wr), .rec_ok(rec_ok),
    .rec_err(rec_err), .load_done(load_done), .start_addr(start_addr), .loading(loading));
  srec_host srec_host_inst (.clk(clk), .ch(ch));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (mem_wr.en === 1'b1) begin
      wa.push_back(mem_wr.addr);
      wd.push_back(mem_wr.data);
    end
    if (rec_ok === 1'b1) n_ok++;
    if (rec_err === 1'b1) n_err++;
    if (load_done === 1'b1) n_done++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task results;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task clr;
    wa.delete();
    wd.delete();
    n_ok = 0;
    n_err = 0;
    n_done = 0;
  endtask : clr

  // Builds a well-formed S1 record whose data bytes count up from zero.
  function automatic string mk(input logic [15:0] a, input int n);
    logic [7:0] s;
    string      r;
    s = 8'(n + 3) + a[15:8] + a[7:0];
    r = $sformatf("S1%02X%04X", n + 3, a);
    for (int i = 0; i < n; i++) begin
      s = s + 8'(i);
      r = {r, $sformatf("%02X", i[7:0])};
    end
    return {r, $sformatf("%02X", ~s)};
  endfunction : mk

  task t_example;
    clr();
    srec_host_inst.send("S00600004844521B\r\n", 1);
    chk("loading_after_header", 32'h0, loading);
    srec_host_inst.send("S1130000285F245F2212226A000424290008237C2A\r\n", 0);
    chk("loading_after_s1", 32'h1, loading);
    srec_host_inst.send("S9030000FC", 1);
    srec_host_inst.put(8'h00, 1);
    repeat (3) @(posedge clk);
    #1;
    chk("writes", 32'd16, wa.size());
    chk("first_data", 32'h28, wd[0]);
    chk("second_data", 32'h5F, wd[1]);
    chk("last_addr", 32'h000F, wa[15]);
    chk("last_data", 32'h7C, wd[15]);
    chk("ok_count", 32'd2, n_ok);
    chk("err_count", 32'd0, n_err);
    chk("done_count", 32'd1, n_done);
    chk("loading_end", 32'h0, loading);
    $display("test example done");
  endtask : t_example

  task t_lead;
    clr();
    srec_host_inst.send("S5030000FC\r", 1);
    srec_host_inst.send("10 S1050100abcd81\n", 0);
    srec_host_inst.send("20 S9031234B6\r", 0);
    repeat (3) @(posedge clk);
    #1;
    chk("err_count", 32'd0, n_err);
    chk("writes", 32'd2, wa.size());
    chk("addr0", 32'h0100, wa[0]);
    chk("data0", 32'hAB, wd[0]);
    chk("addr1", 32'h0101, wa[1]);
    chk("data1", 32'hCD, wd[1]);
    chk("done_count", 32'd1, n_done);
    chk("start_addr", 32'h1234, start_addr);
    $display("test lead done");
  endtask : t_lead

  task t_errs;
    clr();
    srec_host_inst.send("S1040010AB40\r", 1);
    srec_host_inst.send("S1040010AB41\r", 1);
    srec_host_inst.send("S5030000FC\r", 1);
    srec_host_inst.send("S1040010ZZ40\r", 1);
    srec_host_inst.send("S1020000FD\r", 1);
    srec_host_inst.send("S9040000FB\r", 1);
    chk("loading_mid", 32'h1, loading);
    srec_host_inst.send("S9030000FC\r", 1);
    repeat (3) @(posedge clk);
    #1;
    chk("ok_count", 32'd2, n_ok);
    chk("err_count", 32'd5, n_err);
    chk("writes", 32'd2, wa.size());
    chk("done_count", 32'd1, n_done);
    chk("start_addr", 32'h0000, start_addr);
    $display("test errors done");
  endtask : t_errs

  task t_maxlen;
    clr();
    srec_host_inst.send(mk(16'hFF00, 252), 0);
    srec_host_inst.send("S9030000FC\n", 0);
    repeat (3) @(posedge clk);
    #1;
    chk("writes", 32'd252, wa.size());
    chk("last_addr", 32'hFFFB, wa[251]);
    chk("last_data", 32'hFB, wd[251]);
    chk("ok_count", 32'd2, n_ok);
    chk("err_count", 32'd0, n_err);
    $display("test max length done");
  endtask : t_maxlen

  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk("reset_loading", 32'h0, loading);
    chk("reset_start", 32'h0, start_addr);
    t_example();
    t_lead();
    t_errs();
    t_maxlen();
    results();
  end
endmodule : srec_loader_tb
